/* rtl/irq_ctrl_pkg.sv */
// Shared constants, types and helpers of the interrupt enable and priority controller
package irq_ctrl_pkg;

    // Source count and index width
    localparam int NUM_SRC = 11;
    localparam int IDX_W   = 4;

    // Register offsets on the special-function register port
    localparam logic [7:0] OFF_IEN_A       = 8'hA8;
    localparam logic [7:0] OFF_PRIO_LOW_A  = 8'hB8;
    localparam logic [7:0] OFF_PRIO_HIGH_A = 8'hB7;
    localparam logic [7:0] OFF_IEN_B       = 8'hB1;
    localparam logic [7:0] OFF_PRIO_LOW_B  = 8'hB2;
    localparam logic [7:0] OFF_PRIO_HIGH_B = 8'hB3;
    localparam logic [7:0] OFF_EVT_STATUS  = 8'hC0;
    localparam logic [7:0] OFF_EVT_MASK    = 8'hC1;
    localparam logic [7:0] OFF_SVC_STATE   = 8'hC2;

    // Bit-addressable registers: bit address is base plus bit number
    localparam logic [7:0] BIT_BASE_IEN_A      = 8'hA8;
    localparam logic [7:0] BIT_BASE_PRIO_LOW_A = 8'hB8;

    // Implemented bits and values after reset
    localparam logic [7:0] MASK_IEN_A  = 8'hFF;
    localparam logic [7:0] MASK_PRIO_A = 8'h7F;
    localparam logic [7:0] MASK_B      = 8'h47;
    localparam logic [7:0] RESET_REG   = 8'h00;

    // Field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int BIT_A_EXT0    = 0;
    localparam int BIT_A_TIMER0  = 1;
    localparam int BIT_A_EXT1    = 2;
    localparam int BIT_A_TIMER1  = 3;
    localparam int BIT_A_SERIAL  = 4;
    localparam int BIT_A_TIMER2  = 5;
    localparam int BIT_A_PCA     = 6;
    localparam int BIT_B_KEYPAD  = 0;
    localparam int BIT_B_TWI     = 1;
    localparam int BIT_B_SPI     = 2;
    localparam int BIT_B_USB     = 6;

    // Vector per source, sources ordered by polling rank
    localparam logic [15:0] VECTOR_TABLE [NUM_SRC] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0033, 16'h0023,
        16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h006B};

    // Event status bits
    localparam int EVT_W           = 4;
    localparam int EVT_ACCEPT      = 0;
    localparam int EVT_NESTED      = 1;
    localparam int EVT_STRAY_RET   = 2;
    localparam int EVT_ACK_REFUSED = 3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_OFFER = 3'b010,
        ST_HOLD  = 3'b100
    } offer_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic       value;
    } bit_req_t;

    typedef struct packed {
        logic             valid;
        logic [IDX_W-1:0] idx;
        logic [1:0]       level;
    } arb_result_t;

    // Gathers per-source bits from the two register groups into polling order
    function automatic logic [NUM_SRC-1:0] src_map(input logic [7:0] a, input logic [7:0] b);
        src_map = {b[BIT_B_USB], b[BIT_B_SPI], b[BIT_B_TWI], b[BIT_B_KEYPAD], a[BIT_A_TIMER2],
                   a[BIT_A_SERIAL], a[BIT_A_PCA], a[BIT_A_TIMER1], a[BIT_A_EXT1], a[BIT_A_TIMER0],
                   a[BIT_A_EXT0]};
    endfunction : src_map

endpackage : irq_ctrl_pkg

/* rtl/irq_enable_priority.sv */
// Interrupt enable and four-level priority controller facing the processor core
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Eleven sources: two pins, three timers, serial, SPI, keypad, TWI, USB, PCA.
// - Every source has its own enable; a disabled source is never taken.
// - Bit 7 of enable register A gates every interrupt globally.
// - Enable register A bits 6..0: PCA, timer 2, serial, timer 1, ext1, timer 0, ext0.
// - Enable register A resets to zero and its bits are individually writable.
// - Level is high bit then low bit: 00 lowest, 11 highest.
// - Priority-low register A bits 6..0 follow the enable register A layout.
// - PCA vector 0033H, keypad 003BH, SPI 004BH, others at classic addresses.
// - Only a strictly higher level preempts; level 3 is never preempted.
// - Simultaneous requests of different level: the higher level is served.
// - Equal levels resolve by fixed polling rank.
// - Vectors per table; PCA polls fifth, ahead of serial and timer 2.
// - Priority-high register A holds high bits at the priority-low A positions.
// - Enable register B: USB bit 6, SPI 2, TWI 1, keypad 0, reset zero.
module irq_enable_priority
    import irq_ctrl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               ce_in,
    // Register port
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    input  wire logic [7:0]         reg_addr_in,
    input  wire logic [7:0]         reg_wdata_in,
    output logic      [7:0]         reg_rdata_out,
    // Single-bit write port
    input  wire logic               bit_wr_in,
    input  wire logic [7:0]         bit_addr_in,
    input  wire logic               bit_value_in,
    // Source request flags in polling order
    input  wire logic [NUM_SRC-1:0] src_req_in,
    output logic      [NUM_SRC-1:0] src_ack_out,
    // Core side
    output logic                    core_irq_out,
    output logic      [15:0]        core_vector_out,
    input  wire logic               core_ack_in,
    input  wire logic               core_return_in,
    // Event interrupt
    output logic                    int_out
);

    typedef struct packed {
        offer_state_t       st;
        logic [7:0]         ien_a;
        logic [7:0]         ien_b;
        logic [7:0]         prio_low_a;
        logic [7:0]         prio_high_a;
        logic [7:0]         prio_low_b;
        logic [7:0]         prio_high_b;
        logic [EVT_W-1:0]   evt_status;
        logic [EVT_W-1:0]   evt_mask;
        logic [3:0]         active;
        logic [IDX_W-1:0]   offer_idx;
        logic [1:0]         offer_level;
        logic [15:0]        vector;
        logic [NUM_SRC-1:0] ack_src;
        logic [7:0]         rdata;
    } state_t;

    state_t   state;
    state_t   next_state;
    reg_req_t bus;
    bit_req_t bit_req;

    arb_result_t        win;
    logic [NUM_SRC-1:0] en_vec;
    logic [NUM_SRC-1:0] gated_req;
    logic [NUM_SRC-1:0] lvl_high;
    logic [NUM_SRC-1:0] lvl_low;
    logic               accept;
    logic               still_winner;
    logic [3:0]         trk_next_active;
    logic               trk_top_valid;
    logic [1:0]         trk_top_level;
    logic               trk_allowed;
    logic               trk_stray;

    assign bus     = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};
    assign bit_req = '{wr: bit_wr_in, addr: bit_addr_in, value: bit_value_in};

    // Per-source enables and level bits in polling order
    assign en_vec    = src_map(state.ien_a, state.ien_b);
    assign lvl_low   = src_map(state.prio_low_a, state.prio_low_b);
    assign lvl_high  = src_map(state.prio_high_a, state.prio_high_b);
    assign gated_req = src_req_in & en_vec & {NUM_SRC{state.ien_a[GLOBAL_EN_BIT]}};

    irq_level_arbiter u_arbiter (
        .req_in      (gated_req),
        .lvl_high_in (lvl_high),
        .lvl_low_in  (lvl_low),
        .result_out  (win)
    );

    // Offer is still good only if the same source wins at the same level
    assign still_winner = win.valid && (win.idx == state.offer_idx) && (win.level == state.offer_level);
    assign accept       = ce_in && (state.st == ST_OFFER) && core_ack_in && still_winner && trk_allowed;

    irq_service_tracker u_tracker (
        .active_in        (state.active),
        .accept_in        (accept),
        .return_in        (ce_in && core_return_in),
        .cand_level_in    (state.st == ST_OFFER ? state.offer_level : win.level),
        .next_active_out  (trk_next_active),
        .top_valid_out    (trk_top_valid),
        .top_level_out    (trk_top_level),
        .cand_allowed_out (trk_allowed),
        .stray_return_out (trk_stray)
    );

    // Register read mux, reserved bits read as zero
    function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] addr,
                                            input logic top_valid, input logic [1:0] top_level);
        case (addr)
            OFF_IEN_A:       read_reg = s.ien_a;
            OFF_IEN_B:       read_reg = s.ien_b;
            OFF_PRIO_LOW_A:  read_reg = s.prio_low_a & MASK_PRIO_A;
            OFF_PRIO_HIGH_A: read_reg = s.prio_high_a;
            OFF_PRIO_LOW_B:  read_reg = s.prio_low_b;
            OFF_PRIO_HIGH_B: read_reg = s.prio_high_b;
            OFF_EVT_STATUS:  read_reg = {4'h0, s.evt_status};
            OFF_EVT_MASK:    read_reg = {4'h0, s.evt_mask};
            OFF_SVC_STATE:   read_reg = {top_valid, top_level, 1'b0, s.active};
            default:         read_reg = 8'h00;
        endcase
    endfunction : read_reg

    always_comb begin
        logic [EVT_W-1:0] evt_set;
        logic [EVT_W-1:0] evt_clr;
        evt_set    = '0;
        evt_clr    = '0;
        next_state = state;

        // Byte writes
        if (bus.wr) begin
            case (bus.addr)
                OFF_IEN_A:       next_state.ien_a       = bus.wdata & MASK_IEN_A;
                OFF_IEN_B:       next_state.ien_b       = bus.wdata & MASK_B;
                OFF_PRIO_LOW_A:  next_state.prio_low_a  = bus.wdata & MASK_PRIO_A;
                OFF_PRIO_HIGH_A: next_state.prio_high_a = bus.wdata & MASK_PRIO_A;
                OFF_PRIO_LOW_B:  next_state.prio_low_b  = bus.wdata & MASK_B;
                OFF_PRIO_HIGH_B: next_state.prio_high_b = bus.wdata & MASK_B;
                OFF_EVT_STATUS:  evt_clr                = bus.wdata[EVT_W-1:0];
                OFF_EVT_MASK:    next_state.evt_mask    = bus.wdata[EVT_W-1:0];
                default:         next_state.evt_mask    = state.evt_mask;
            endcase
        end

        // Single-bit writes
        if (bit_req.wr && (bit_req.addr[7:3] == BIT_BASE_IEN_A[7:3])) begin
            next_state.ien_a[bit_req.addr[2:0]] = bit_req.value;
        end
        if (bit_req.wr && (bit_req.addr[7:3] == BIT_BASE_PRIO_LOW_A[7:3]) && (bit_req.addr[2:0] != 3'h7)) begin
            next_state.prio_low_a[bit_req.addr[2:0]] = bit_req.value;
        end

        // Read data stands only in the cycle after the strobe
        next_state.rdata = bus.rd ? read_reg(state, bus.addr, trk_top_valid, trk_top_level) : 8'h00;

        next_state.ack_src = '0;
        next_state.active  = trk_next_active;

        case (state.st)
            ST_IDLE: begin
                if (win.valid && trk_allowed) begin
                    next_state.st          = ST_OFFER;
                    next_state.offer_idx   = win.idx;
                    next_state.offer_level = win.level;
                    next_state.vector      = VECTOR_TABLE[win.idx];
                end
            end
            ST_OFFER: begin
                if (accept) begin
                    next_state.st                     = ST_HOLD;
                    next_state.ack_src[state.offer_idx] = 1'b1;
                    evt_set[EVT_ACCEPT]               = 1'b1;
                    evt_set[EVT_NESTED]               = trk_top_valid;
                end else if (core_ack_in) begin
                    next_state.st            = ST_IDLE;
                    evt_set[EVT_ACK_REFUSED] = 1'b1;
                end else if (!(still_winner && trk_allowed)) begin
                    // Withdraw a stale offer; a fresh one follows from idle
                    next_state.st = ST_IDLE;
                end
            end
            ST_HOLD: begin
                // One cycle for the source to drop its flag
                next_state.st = ST_IDLE;
            end
            default: begin
                next_state.st = ST_IDLE;
            end
        endcase

        if (trk_stray) begin
            evt_set[EVT_STRAY_RET] = 1'b1;
        end

        // Set wins over a same-cycle clear
        next_state.evt_status = (state.evt_status & ~evt_clr) | evt_set;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state             <= '0;
            state.st          <= ST_IDLE;
            state.ien_a       <= RESET_REG;
            state.ien_b       <= RESET_REG;
            state.prio_low_a  <= RESET_REG;
            state.prio_high_a <= RESET_REG;
            state.prio_low_b  <= RESET_REG;
            state.prio_high_b <= RESET_REG;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // Outputs
    assign reg_rdata_out   = state.rdata;
    assign src_ack_out     = state.ack_src;
    assign core_irq_out    = (state.st == ST_OFFER);
    assign core_vector_out = state.vector;
    assign int_out         = |(state.evt_status & state.evt_mask);

endmodule : irq_enable_priority
`default_nettype wire

/* rtl/irq_level_arbiter.sv */
// Picks the highest-level request, lowest polling rank within a level
`timescale 1ns/1ps
`default_nettype none
module irq_level_arbiter
    import irq_ctrl_pkg::*;
(
    // Gated requests and per-source level bits
    input  wire logic [NUM_SRC-1:0] req_in,
    input  wire logic [NUM_SRC-1:0] lvl_high_in,
    input  wire logic [NUM_SRC-1:0] lvl_low_in,
    // Winner
    output arb_result_t             result_out
);

    // Later assignments win: levels ascend, ranks descend
    always_comb begin
        result_out = '0;
        for (int l = 0; l < 4; l++) begin
            for (int i = NUM_SRC - 1; i >= 0; i--) begin
                if (req_in[i] && ({lvl_high_in[i], lvl_low_in[i]} == 2'(l))) begin
                    result_out.valid = 1'b1;
                    result_out.idx   = IDX_W'(i);
                    result_out.level = 2'(l);
                end
            end
        end
    end

endmodule : irq_level_arbiter
`default_nettype wire

/* rtl/irq_service_tracker.sv */
// Tracks in-service levels and decides whether a candidate may preempt
`timescale 1ns/1ps
`default_nettype none
module irq_service_tracker
    import irq_ctrl_pkg::*;
(
    // Current in-service set and events
    input  wire logic [3:0] active_in,
    input  wire logic       accept_in,
    input  wire logic       return_in,
    input  wire logic [1:0] cand_level_in,
    // Results
    output logic [3:0]      next_active_out,
    output logic            top_valid_out,
    output logic [1:0]      top_level_out,
    output logic            cand_allowed_out,
    output logic            stray_return_out
);

    always_comb begin
        top_valid_out = 1'b0;
        top_level_out = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (active_in[l]) begin
                top_valid_out = 1'b1;
                top_level_out = 2'(l);
            end
        end
        // Only a strictly higher level may preempt; level 3 never is
        cand_allowed_out = !top_valid_out || (cand_level_in > top_level_out);
        stray_return_out = return_in && !top_valid_out;
        next_active_out  = active_in;
        if (return_in && top_valid_out) begin
            next_active_out[top_level_out] = 1'b0;
        end
        if (accept_in) begin
            next_active_out[cand_level_in] = 1'b1;
        end
    end

endmodule : irq_service_tracker
`default_nettype wire

/* test/core_partner_model.sv */
// Behavioural processor core that takes offered interrupts and returns from them
`timescale 1ns/1ps
`default_nettype none
module core_partner_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Offer from the controller
    input  wire logic        irq_in,
    input  wire logic [15:0] vector_in,
    // Control from the bench
    input  wire logic [3:0]  ack_wait_in,
    input  wire logic        ret_req_in,
    // Answers to the controller
    output logic             ack_out,
    output logic             ret_out,
    // Record of taken vectors
    output logic [15:0]      taken_vec_out,
    output logic [7:0]       taken_cnt_out
);
    logic [3:0] wait_cnt;

    // Acknowledges a standing offer after a chosen latency, one pulse each
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_out <= 1'b0;
            ret_out <= 1'b0;
            wait_cnt <= 4'h0;
            taken_vec_out <= 16'h0000;
            taken_cnt_out <= 8'h00;
        end else begin
            ack_out <= 1'b0;
            ret_out <= ret_req_in;
            if (irq_in && !ack_out) begin
                if (wait_cnt == ack_wait_in) begin
                    ack_out <= 1'b1;
                    taken_vec_out <= vector_in;
                    taken_cnt_out <= taken_cnt_out + 8'h01;
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else begin
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule : core_partner_model
`default_nettype wire

/* test/irq_enable_priority_assertions.sv */
// Port-level concurrent checks of the interrupt enable and priority controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker
    import irq_ctrl_pkg::*;
(
    // Clock, reset, enable
    input wire logic               clk_in,
    input wire logic               rst_n_in,
    input wire logic               ce_in,
    // Register port
    input wire logic               reg_rd_in,
    input wire logic [7:0]         reg_addr_in,
    input wire logic [7:0]         reg_rdata_out,
    // Sources and core
    input wire logic [NUM_SRC-1:0] src_req_in,
    input wire logic [NUM_SRC-1:0] src_ack_out,
    input wire logic               core_irq_out,
    input wire logic [15:0]        core_vector_out,
    input wire logic               core_ack_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_taken;
        core_irq_out && core_ack_in && ce_in;
    endsequence
    sequence s_quiet;
        (src_req_in == '0) [*2];
    endsequence

    chk_rdata_idle: assert property (ce_in && !reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    chk_reserved_bit: assert property (ce_in && reg_rd_in && reg_addr_in == OFF_PRIO_LOW_A |=> !reg_rdata_out[7])
        else $error("reserved priority bit reads one");
    chk_ack_onehot: assert property ($onehot0(src_ack_out))
        else $error("more than one source accepted");
    chk_ack_cause: assert property (src_ack_out != '0 |-> $past(core_ack_in && core_irq_out))
        else $error("source accepted without core acknowledge");
    chk_ack_pulse: assert property (ce_in && src_ack_out != '0 |=> src_ack_out == '0)
        else $error("accept pulse longer than one cycle");
    chk_ack_request: assert property (src_ack_out != '0 |-> ($past(src_req_in) & src_ack_out) != '0)
        else $error("accepted source had no request");
    chk_irq_drop: assert property (s_taken |=> !core_irq_out)
        else $error("offer stands after acknowledge");
    chk_quiet_offer: assert property (s_quiet |=> !core_irq_out)
        else $error("offer without any request");
    chk_vector_map: assert property (core_irq_out |-> core_vector_out inside {16'h0003, 16'h000B, 16'h0013,
        16'h001B, 16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h0043, 16'h004B, 16'h006B})
        else $error("offered vector outside the table");
    chk_offer_cause: assert property ($rose(core_irq_out) |-> $past(src_req_in) != '0)
        else $error("offer raised with no request");
endmodule : irq_ctrl_checker
`default_nettype wire

/* test/irq_enable_priority_test.sv */
// Self-checking bench for the interrupt enable and priority controller
`timescale 1ns/1ps
`default_nettype none
module irq_enable_priority_test import irq_ctrl_pkg::*;;
    logic               clk_in = 1'b0;
    logic               rst_n_in = 1'b0;
    logic               reg_wr_in = 1'b0;
    logic               reg_rd_in = 1'b0;
    logic [7:0]         reg_addr_in = 8'h00;
    logic [7:0]         reg_wdata_in = 8'h00;
    logic [7:0]         reg_rdata_out;
    logic               bit_wr_in = 1'b0;
    logic [7:0]         bit_addr_in = 8'h00;
    logic               bit_value_in = 1'b0;
    logic [NUM_SRC-1:0] src_req_in = '0;
    logic [NUM_SRC-1:0] src_ack_out;
    logic               core_irq_out;
    logic [15:0]        core_vector_out;
    logic               core_ack_in;
    logic               core_return_in;
    logic               int_out;
    logic [3:0]         ack_wait = 4'h0;
    logic               ret_req = 1'b0;
    logic [15:0]        taken_vec;
    logic [7:0]         taken_cnt;
    int                 failures = 0;
    int                 check_count = 0;
    // Vector per polling rank; enable place as {register B, bit}
    logic [15:0]        vec_exp [NUM_SRC] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0033, 16'h0023,
                                              16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h006B};
    logic [3:0]         en_pos [NUM_SRC] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hE};

    always #2.5 clk_in = ~clk_in;

    irq_enable_priority dut (
        .clk_in, .rst_n_in, .ce_in(1'b1), .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
        .reg_rdata_out, .bit_wr_in, .bit_addr_in, .bit_value_in, .src_req_in, .src_ack_out,
        .core_irq_out, .core_vector_out, .core_ack_in, .core_return_in, .int_out);
    core_partner_model core (
        .clk_in, .rst_n_in, .irq_in(core_irq_out), .vector_in(core_vector_out), .ack_wait_in(ack_wait),
        .ret_req_in(ret_req), .ack_out(core_ack_in), .ret_out(core_return_in), .taken_vec_out(taken_vec),
        .taken_cnt_out(taken_cnt));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        cmp(nm, {8'h00, exp}, {8'h00, reg_rdata_out});
    endtask : rd

    task automatic bw(input logic [7:0] a, input logic v);
        @(posedge clk_in);
        bit_wr_in <= 1'b1;
        bit_addr_in <= a;
        bit_value_in <= v;
        @(posedge clk_in);
        bit_wr_in <= 1'b0;
    endtask : bw

    // Waits for the core to take an offer and compares its vector
    task automatic take(input logic [15:0] exp);
        logic [7:0] n;
        n = taken_cnt;
        for (int i = 0; i < 40 && taken_cnt == n; i++) @(posedge clk_in);
        if (taken_cnt == n) begin
            failures++;
            stop_test();
        end else begin
            cmp("vector", exp, taken_vec);
        end
        repeat (3) @(posedge clk_in);
    endtask : take

    task automatic ret;
        @(posedge clk_in);
        ret_req <= 1'b1;
        @(posedge clk_in);
        ret_req <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask : ret

    task automatic quiet(input string nm);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(posedge clk_in);
            seen = seen | core_irq_out;
        end
        cmp(nm, 16'h0000, {15'h0000, seen});
    endtask : quiet

    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd("enable a", OFF_IEN_A, 8'h00);
        rd("enable b", OFF_IEN_B, 8'h00);
        wr(OFF_IEN_B, 8'hFF);
        rd("enable b", OFF_IEN_B, 8'h47);
        wr(OFF_PRIO_LOW_A, 8'h7F);
        rd("prio low a", OFF_PRIO_LOW_A, 8'h7F);
        wr(OFF_PRIO_HIGH_A, 8'h7F);
        rd("prio high a", OFF_PRIO_HIGH_A, 8'h7F);
        wr(8'h55, 8'hFF);
        rd("unmapped", 8'h55, 8'h00);
        bw(BIT_BASE_IEN_A + 8'h07, 1'b1);
        bw(BIT_BASE_IEN_A + 8'h02, 1'b1);
        rd("enable a bits", OFF_IEN_A, 8'h84);
        bw(BIT_BASE_PRIO_LOW_A + 8'h06, 1'b0);
        rd("prio low a bits", OFF_PRIO_LOW_A, 8'h3F);
        wr(OFF_PRIO_LOW_A, 8'h00);
        wr(OFF_PRIO_HIGH_A, 8'h00);
        $display("test registers done");
        // Requests rise only once enable register B is cleared and the global enable bit of register A is off
        wr(OFF_IEN_B, 8'h00);
        wr(OFF_IEN_A, 8'h7F);
        src_req_in <= '1;
        quiet("no global");
        wr(OFF_IEN_A, 8'h80);
        quiet("no source");
        for (int i = 0; i < NUM_SRC; i++) begin
            wr(OFF_IEN_B, en_pos[i][3] ? (8'h01 << en_pos[i][2:0]) : 8'h00);
            wr(OFF_IEN_A, en_pos[i][3] ? 8'h80 : (8'h80 | (8'h01 << en_pos[i][2:0])));
            ack_wait <= 4'(i);
            take(vec_exp[i]);
            wr(OFF_IEN_A, 8'h00);
            ret();
        end
        $display("test enables done");
        ack_wait <= 4'h0;
        wr(OFF_IEN_B, 8'h47);
        wr(OFF_IEN_A, 8'hFF);
        for (int i = 0; i < NUM_SRC; i++) begin
            take(vec_exp[i]);
            src_req_in[i] <= 1'b0;
            ret();
        end
        $display("test polling done");
        wr(OFF_PRIO_HIGH_B, 8'h40);
        wr(OFF_PRIO_LOW_B, 8'h40);
        wr(OFF_PRIO_HIGH_A, 8'h40);
        wr(OFF_PRIO_LOW_A, 8'h10);
        src_req_in <= '1;
        take(16'h006B);
        rd("in service", OFF_SVC_STATE, 8'hE8);
        quiet("top level busy");
        src_req_in[10] <= 1'b0;
        ret();
        take(16'h0033);
        src_req_in <= (src_req_in & 11'h3EF) | 11'h400;
        take(16'h006B);
        rd("nested service", OFF_SVC_STATE, 8'hEC);
        src_req_in[10] <= 1'b0;
        ret();
        ret();
        take(16'h0023);
        src_req_in[5] <= 1'b0;
        quiet("lower level blocked");
        ret();
        take(16'h0003);
        quiet("equal level blocked");
        src_req_in <= '0;
        ret();
        rd("service idle", OFF_SVC_STATE, 8'h00);
        $display("test levels done");
        rd("events", OFF_EVT_STATUS, 8'h03);
        cmp("int masked", 16'h0000, {15'h0000, int_out});
        wr(OFF_EVT_MASK, 8'h02);
        repeat (2) @(posedge clk_in);
        #1;
        cmp("int raised", 16'h0001, {15'h0000, int_out});
        wr(OFF_EVT_STATUS, 8'h02);
        repeat (2) @(posedge clk_in);
        #1;
        cmp("int cleared", 16'h0000, {15'h0000, int_out});
        // Return with nothing in service raises the stray-return event
        ret();
        rd("events", OFF_EVT_STATUS, 8'h05);
        $display("test events done");
        stop_test();
    end
endmodule : irq_enable_priority_test

bind irq_enable_priority irq_ctrl_checker chk (
    .clk_in, .rst_n_in, .ce_in, .reg_rd_in, .reg_addr_in, .reg_rdata_out, .src_req_in, .src_ack_out,
    .core_irq_out, .core_vector_out, .core_ack_in);
`default_nettype wire
